// ==== pkg/rebs_pkg.sv ====
package rebs_pkg;

	// ************************************************************
	// Board geometry
	// ************************************************************
	localparam int ROM_CHIP_ABITS   = 11;          // 2 kbytes per chip
	localparam int ROM_MAX_CHIPS    = 12;          // 24 kbytes at most
	localparam int RAM_ABITS        = 8;           // 256 bytes scratch
	localparam int RAM_WORDS        = 256;
	localparam int DATA_BITS        = 8;
	localparam int ADDR_BITS        = 16;
	localparam int STROBE_COUNT     = 3;           // Read strobes A, B, C

	// ************************************************************
	// Default decode table
	// ************************************************************
	localparam logic [15:0] ROM_BASE_DEF    = 16'h8800;  // After 32k basic plus 2k boot
	localparam logic [15:0] RAM_BASE_DEF    = 16'hF800;  // Scratch RAM window
	localparam logic [3:0]  ROM_FITTED_DEF  = 4'hC;      // Chips fitted
	localparam logic [3:0]  STROBE_A_LAST   = 4'h3;      // Chips 0..3 on strobe A
	localparam logic [3:0]  STROBE_B_LAST   = 4'h7;      // Not used; strobe B takes chips 4..11
	localparam logic [3:0]  DEC_GROUP_SIZE  = 4'h8;      // Chips per decoder

	// ************************************************************
	// Bus request and strobe bundles
	// ************************************************************
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        read_not_write;
		logic        valid;
	} rebs_bus_s;

	typedef struct packed {
		logic strobe_a;
		logic strobe_b;
		logic strobe_c;
		logic ram_write_en;
	} rebs_block_s;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_LATCH,
		SEQ_STORE
	} rebs_seq_e;

endpackage

// ==== hdl/rebs_board.sv ====
`timescale 1ns/1ps
module rebs_board #(
	parameter logic [15:0] ROM_BASE   = rebs_pkg::ROM_BASE_DEF,
	parameter logic [15:0] RAM_BASE   = rebs_pkg::RAM_BASE_DEF,
	parameter logic [3:0]  ROM_FITTED = rebs_pkg::ROM_FITTED_DEF
) (
	input  wire logic                 core_clk_in,
	input  wire logic                 reset_in,
	input  wire logic                 phase2_in,
	input  wire rebs_pkg::rebs_bus_s  bus_in,
	input  wire logic [7:0]           rom_data_in,
	output logic [11:0]               chip_en_out,
	output rebs_pkg::rebs_block_s     block_en_out,
	output logic                      buffer_en_out,
	output logic [7:0]                rdata_out,
	output logic                      rdata_valid_out,
	output logic                      scratch_store_pulse_out,
	output logic                      store_busy_out
);

	// ************************************************************
	// Decode helpers
	// ************************************************************
	// Distance of an address above a window base
	// Addresses below the base wrap to a large offset
	function automatic logic [15:0] win_offset(
		input logic [15:0] addr,
		input logic [15:0] base
	);
		win_offset = addr - base;
	endfunction

	// Chip slot of a read-only offset
	// One slot per 2k chip, counted from the region base
	function automatic logic [3:0] chip_slot(input logic [15:0] off);
		chip_slot = off[rebs_pkg::ROM_CHIP_ABITS +: 4];
	endfunction

	// One-hot line of a decoder
	// All lines low while the decoder is not enabled
	function automatic logic [7:0] onehot_sel(
		input logic [2:0] idx,
		input logic       en
	);
		onehot_sel = en ? (8'h01 << idx) : 8'h00;
	endfunction

	// ************************************************************
	// Decode table
	// ************************************************************
	logic [15:0] rom_off;
	logic [15:0] ram_off;
	logic [3:0]  chip_idx;
	logic        rom_hit;
	logic        ram_hit;
	logic        in_phase;

	assign rom_off  = win_offset(bus_in.addr, ROM_BASE);
	assign ram_off  = win_offset(bus_in.addr, RAM_BASE);
	assign chip_idx = chip_slot(rom_off);
	assign rom_hit  = (bus_in.addr >= ROM_BASE) && (rom_off[15] == 1'b0) && (chip_idx < ROM_FITTED);
	assign ram_hit  = (ram_off[15:8] == 8'h00) && !rom_hit;
	assign in_phase = phase2_in && bus_in.valid;

	// ************************************************************
	// Block and circuit enables
	// ************************************************************
	logic        rd_cyc;
	logic        wr_cyc;
	logic        rom_rd;
	logic [3:0]  grp_idx;
	logic        lo_dec_en;
	logic        hi_dec_en;
	logic [7:0]  lo_dec_sel;
	logic [7:0]  hi_dec_sel;
	logic        strobe_a_w;
	logic        strobe_b_w;
	logic        strobe_c_w;
	logic        ram_we_w;

	// Bus direction qualified by phase two
	assign rd_cyc   = in_phase && bus_in.read_not_write;
	assign wr_cyc   = in_phase && !bus_in.read_not_write;
	assign rom_rd   = rd_cyc && rom_hit;
	assign grp_idx  = chip_idx - rebs_pkg::DEC_GROUP_SIZE;

	// strobes A and B by chip table
	assign strobe_a_w = rom_rd && (chip_idx <= rebs_pkg::STROBE_A_LAST);
	assign strobe_b_w = rom_rd && (chip_idx > rebs_pkg::STROBE_A_LAST);
	assign strobe_c_w = rd_cyc && ram_hit;
	assign ram_we_w   = wr_cyc && ram_hit;

	// One driver for the whole strobe bundle
	assign block_en_out  = '{
		strobe_a:     strobe_a_w,
		strobe_b:     strobe_b_w,
		strobe_c:     strobe_c_w,
		ram_write_en: ram_we_w
	};
	// Output buffers open with any read strobe
	assign buffer_en_out = strobe_a_w || strobe_b_w || strobe_c_w;

	assign lo_dec_en   = rom_rd && (chip_idx < rebs_pkg::DEC_GROUP_SIZE);
	assign hi_dec_en   = rom_rd && (chip_idx >= rebs_pkg::DEC_GROUP_SIZE);
	// Low decoder serves slots 0..7, high decoder slots 8..11
	assign lo_dec_sel  = onehot_sel(chip_idx[2:0], lo_dec_en);
	assign hi_dec_sel  = onehot_sel({1'b0, grp_idx[1:0]}, hi_dec_en);
	// Only four lines of the high decoder are wired to chips
	assign chip_en_out = {hi_dec_sel[3:0], lo_dec_sel};

	// ************************************************************
	// Scratch RAM and store sequencer
	// ************************************************************
	// 256-byte scratch store
	logic [7:0]  ram_q [rebs_pkg::RAM_WORDS];
	logic [7:0]  lat_addr_q;
	logic [7:0]  lat_data_q;
	logic        store_q;
	rebs_pkg::rebs_seq_e seq_q;
	rebs_pkg::rebs_seq_e seq_d;

	always_comb begin
		case (seq_q)
			rebs_pkg::SEQ_IDLE:  seq_d = block_en_out.ram_write_en ? rebs_pkg::SEQ_LATCH : rebs_pkg::SEQ_IDLE;
			rebs_pkg::SEQ_LATCH: seq_d = rebs_pkg::SEQ_STORE;
			rebs_pkg::SEQ_STORE: seq_d = rebs_pkg::SEQ_IDLE;
			default:             seq_d = rebs_pkg::SEQ_IDLE;
		endcase
	end

	// Sequencer state and latches
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			seq_q      <= rebs_pkg::SEQ_IDLE;
			lat_addr_q <= 8'h00;
			lat_data_q <= 8'h00;
			store_q    <= 1'b0;
		end else begin
			seq_q   <= seq_d;
			store_q <= (seq_d == rebs_pkg::SEQ_STORE);
			if (seq_q == rebs_pkg::SEQ_IDLE && block_en_out.ram_write_en) begin
				lat_addr_q <= ram_off[7:0];
				lat_data_q <= bus_in.wdata;
			end
		end
	end

	// store latched data at latched cell
	always_ff @(posedge core_clk_in) begin
		if (store_q) begin
			ram_q[lat_addr_q] <= lat_data_q;
		end
	end

	assign scratch_store_pulse_out = store_q;
	assign store_busy_out          = (seq_q != rebs_pkg::SEQ_IDLE);

	// ************************************************************
	// Read data path
	// ************************************************************
	// Registered read byte, valid one cycle after its strobe
	// Scratch reads come from the store, chip reads from the pins
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			rdata_out       <= 8'h00;
			rdata_valid_out <= 1'b0;
		end else begin
			rdata_valid_out <= buffer_en_out;
			if (block_en_out.strobe_c) begin
				rdata_out <= ram_q[ram_off[7:0]];
			end else if (buffer_en_out) begin
				rdata_out <= rom_data_in;
			end
		end
	end

	// ************************************************************
	// Timing notes
	// ************************************************************
	// Strobes are pure decode of the current bus cycle, so they
	// follow the request combinationally and fall with phase two.
	// Chip enables and strobes never rise outside phase two, which
	// keeps the output buffers closed while the bus turns around.
	// A scratch write is stored two cycles after its bus cycle;
	// a read of the same cell in either of the next two cycles sees the old
	// byte, and the bus master is expected to leave that gap.
	// Writes arriving while a store is pending are not latched,
	// so masters space scratch writes by at least three cycles.
	// Scratch contents survive reset, as settings must persist.
	// Unfitted chip slots and unmapped addresses raise no enable
	// and leave the output buffers closed.
	// The decode table lives in the parameters, so a board with
	// fewer chips or another map needs no change to this logic.

endmodule

// ==== testbench/rebs_properties.sv ====
`timescale 1ns/1ps
module rebs_chk (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic phase2_in,
	input wire rebs_pkg::rebs_bus_s bus_in,
	input wire logic [11:0] chip_en_out,
	input wire rebs_pkg::rebs_block_s block_en_out,
	input wire logic buffer_en_out,
	input wire logic scratch_store_pulse_out,
	input wire logic store_busy_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	wire logic [3:0] be = block_en_out;
	sequence s_store; store_busy_out ##1 scratch_store_pulse_out; endsequence
	a_phase_two: assert property (|be |-> phase2_in) else $error("strobe off phase");
	a_write_dir: assert property (be[0] |-> !bus_in.read_not_write) else $error("bad write");
	a_ram_read: assert property (be[1] |-> bus_in.read_not_write) else $error("bad read");
	a_chip_hot: assert property ($onehot0(chip_en_out)) else $error("chip enables");
	a_buf_open: assert property (buffer_en_out == |be[3:1]) else $error("buffer enable");
	a_store_seq: assert property (be[0] && !store_busy_out |=> s_store) else $error("store order");
	a_store_once: assert property (scratch_store_pulse_out |=> !scratch_store_pulse_out) else $error("long store");
	a_no_unfit: assert property (bus_in.addr[15:11] == 5'h1D |-> !chip_en_out) else $error("unfitted");
endmodule
bind rebs_board rebs_chk rebs_chk_inst (.*);

// ==== testbench/rebs_rom.sv ====
`timescale 1ns/1ps
module rebs_rom (
	input wire logic [11:0] en_in,
	input wire logic [15:0] addr_in,
	output logic [7:0] data_out
);
	assign data_out = (|en_in) ? addr_in[7:0] ^ 8'h5A : ~addr_in[7:0];
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
	logic core_clk_in = 0, reset_in = 1, phase2_in = 0, rdata_valid_out, buffer_en_out;
	logic scratch_store_pulse_out, store_busy_out;
	rebs_pkg::rebs_bus_s bus_in = '0;
	rebs_pkg::rebs_block_s block_en_out;
	logic [11:0] chip_en_out;
	logic [7:0] rom_data_in, rdata_out, exp_q[$];
	logic [15:0] a;
	int err_total = 0, tests_run = 0;
	rebs_board rebs_board_inst (.*);
	rebs_rom rebs_rom_inst (.en_in(chip_en_out), .addr_in(bus_in.addr), .data_out(rom_data_in));
	initial forever #2.5 core_clk_in = ~core_clk_in;
	task automatic tally(string n, logic [15:0] e, logic [15:0] g);
		tests_run++;
		err_total += (g !== e);
		if (g !== e) $display("unexpected %s exp %h got %h", n, e, g);
	endtask
	task automatic chk_en(logic [15:0] e, logic [15:0] g);
		tally("enables", e, g);
	endtask
	task automatic chk_rd(logic [7:0] e, logic [7:0] g);
		tally("rdata", {8'h00, e}, {8'h00, g});
	endtask
	task automatic chk_store(logic [1:0] e, logic [1:0] g);
		tally("store", {14'h0000, e}, {14'h0000, g});
	endtask
	task automatic op(logic [15:0] ad, logic rw, logic ph, logic [7:0] dt, logic [11:0] c, logic [3:0] b);
		@(posedge core_clk_in);
		bus_in <= '{ad, dt, rw, 1'b1};
		phase2_in <= ph;
		if (|b[3:1]) exp_q.push_back(dt);
		@(negedge core_clk_in);
		chk_en({c, b}, {chip_en_out, block_en_out});
		@(posedge core_clk_in);
		{bus_in.valid, phase2_in} <= 2'b00;
		@(negedge core_clk_in);
		if (b[0]) chk_store(2'b10, {store_busy_out, scratch_store_pulse_out});
		@(negedge core_clk_in);
		if (b[0]) chk_store(2'b11, {store_busy_out, scratch_store_pulse_out});
		repeat (3) @(posedge core_clk_in);
	endtask
	// Read data against oldest note
	always @(negedge core_clk_in) if (rdata_valid_out === 1'b1) chk_rd(exp_q.pop_front(), rdata_out);
	initial begin
		void'($urandom(32'h94DB));
		repeat (4) @(posedge core_clk_in);
		reset_in <= 0;
		for (int i = 0; i < 12; i++) begin
			a = (16'h8800 + (16'(i) << 11)) | 16'($urandom_range(2047));
			op(a, 1, 1, a[7:0] ^ 8'h5A, 12'h001 << i, i < 4 ? 4'h8 : 4'h4);
		end
		op(16'hE800, 1, 1, 8'h00, 12'h000, 4'h0);
		op(16'h9000, 1, 0, 8'h00, 12'h000, 4'h0);
		op(16'h8800, 0, 1, 8'h00, 12'h000, 4'h0);
		repeat (4) begin
			a = {8'hF8, 8'($urandom)};
			op(a, 0, 1, ~a[7:0], 12'h000, 4'h1);
			op(a, 1, 1, ~a[7:0], 12'h000, 4'h2);
		end
		finish_test();
	end
	// Hang guard
	initial begin
		#20000 err_total++;
		finish_test();
	end
	task automatic finish_test();
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
endmodule
